/* File: rtl/shc_standby_ctrl.sv */
// Contract
// - standby entered by halt instruction only while gate pin is high
// - in standby, reset pin low exits standby with a full reset
// - in standby, gate pin low also exits standby
// - after any reset, fetch restarts with program counter at zero
// - standby keeps register contents and lowers current draw
// - reset pin low in normal run restarts the full start sequence
// - no reset and no power loss means execution continues untouched
// - firmware polls power-sense twice; halt only when low seen
// - halt suspends all operation; one word, one machine cycle
`include "shc_consts.svh"
module shc_standby_ctrl
    import shc_pkg::*;
#(
    parameter int PC_W = `SHC_PC_W
) (
    input  wire logic            REF_CLK_I,
    input  wire logic            RESET_N_I,
    input  wire logic            EXTERNAL_CLEAR_N_I,
    input  wire logic            STANDBY_GATE_PIN_I,
    input  wire logic            HALT_EXEC_I,
    input  wire logic            POWER_SENSE_I,
    input  wire logic            PC_ADVANCE_I,
    input  wire logic [PC_W-1:0] PC_NEXT_I,
    output logic      [PC_W-1:0] PC_O,
    output logic                 RUN_EN_O,
    output logic                 STANDBY_O,
    output logic                 LOW_POWER_O,
    output logic                 CORE_RESET_O,
    output logic                 POWER_LOW_SEEN_O
);
    logic       rst_s1_q;
    logic       rst_s2_q;
    logic       clr_q;
    shc_state_e state_q;
    shc_state_e state_d;
    logic [PC_W-1:0] pc_q;
    logic [PC_W-1:0] pc_d;
    logic       seen_q;
    shc_status_s status;

    always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end

    wire rst_n      = rst_s2_q;
    wire ext_clear  = !EXTERNAL_CLEAR_N_I;
    wire in_run     = (state_q == SHC_RUN);
    wire in_halt    = (state_q == SHC_HALT_EXEC);
    wire in_stby    = (state_q == SHC_STANDBY);
    wire halt_ok    = HALT_EXEC_I && STANDBY_GATE_PIN_I;
    wire gate_wake  = in_stby && !STANDBY_GATE_PIN_I;
    wire exit_clear = ext_clear || clr_q;
    wire seen_d     = (seen_q && !clr_q) || !POWER_SENSE_I;

    localparam int              halt_cyc = `SHC_HALT_CYCLES;
    localparam logic [PC_W-1:0] pc_rst   = PC_W'(`SHC_PC_RESET);

    default clocking cb_ref @(posedge REF_CLK_I);
    endclocking
    default disable iff (!rst_n);

    // clear pin low acts in every state, standby included
    always_ff @(posedge REF_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            clr_q <= 1'b1;
        end else begin
            clr_q <= ext_clear;
        end
    end

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            SHC_RUN: begin
                if (halt_ok) begin
                    state_d = SHC_HALT_EXEC;
                end
            end
            SHC_HALT_EXEC: begin
                state_d = SHC_STANDBY;
            end
            SHC_STANDBY: begin
                if (gate_wake) begin
                    state_d = SHC_RUN;
                end
            end
            default: begin
                state_d = SHC_RUN;
            end
        endcase
        if (exit_clear) begin
            state_d = SHC_RUN;
        end
    end

    // pc held in halt and standby, and left unchanged on gate wake
    always_comb begin
        pc_d = pc_q;
        if (in_run && PC_ADVANCE_I) begin
            pc_d = PC_NEXT_I;
        end
        if (clr_q) begin
            pc_d = pc_rst;
        end
    end

    always_ff @(posedge REF_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= SHC_RUN;
            pc_q    <= pc_rst;
        end else begin
            state_q <= state_d;
            pc_q    <= pc_d;
        end
    end

    // sticky power-low flag; a new low beats the clear
    always_ff @(posedge REF_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            seen_q <= 1'b0;
        end else begin
            seen_q <= seen_d;
        end
    end

    assign status = '{
        run_en:    in_run && !clr_q,
        standby:   in_stby,
        low_power: !in_run
    };

    assign PC_O             = pc_q;
    assign RUN_EN_O         = status.run_en;
    assign STANDBY_O        = status.standby;
    assign LOW_POWER_O      = status.low_power;
    assign CORE_RESET_O     = clr_q | !rst_n;
    assign POWER_LOW_SEEN_O = seen_q;

    // guards on state, pc and flag
    a_enter_halt: assert property (
        in_run && halt_ok && !ext_clear && !clr_q
        |=> in_halt ##halt_cyc in_stby)
        else $error("halt with gate high did not enter standby");

    a_no_gate_halt: assert property (
        in_run && HALT_EXEC_I && !STANDBY_GATE_PIN_I
        |=> in_run)
        else $error("halt entered with gate low");

    a_clear_exit: assert property (
        in_stby && ext_clear
        |=> in_run && CORE_RESET_O)
        else $error("clear did not leave standby");

    a_gate_wake: assert property (
        gate_wake && !ext_clear && !clr_q
        |=> in_run && RUN_EN_O)
        else $error("gate wake did not resume run");

    a_wake_resume: assert property (
        gate_wake && !clr_q
        |=> $stable(pc_q))
        else $error("pc moved on gate wake");

    a_pc_zero: assert property (
        clr_q
        |=> pc_q == '0)
        else $error("pc not zero after clear");

    a_hold_pc: assert property (
        !in_run && !clr_q
        |=> $stable(pc_q) && (LOW_POWER_O || in_run))
        else $error("pc lost during standby");

    a_stay_standby: assert property (
        in_stby && STANDBY_GATE_PIN_I && !ext_clear && !clr_q
        |=> in_stby && LOW_POWER_O)
        else $error("standby left without exit condition");

    a_run_clear: assert property (
        in_run && ext_clear
        |=> CORE_RESET_O ##1 pc_q == '0)
        else $error("clear in run did not restart");

    a_clear_reset: assert property (
        ext_clear
        |=> CORE_RESET_O && !RUN_EN_O && in_run)
        else $error("clear did not hold core in reset");

    a_run_on: assert property (
        in_run && !clr_q && !HALT_EXEC_I && PC_ADVANCE_I
        |=> pc_q == $past(PC_NEXT_I))
        else $error("normal run interrupted");

    a_run_idle: assert property (
        in_run && !clr_q && !halt_ok && !ext_clear && !PC_ADVANCE_I
        |=> in_run && $stable(pc_q))
        else $error("run disturbed without cause");

    a_sense_seen: assert property (
        !POWER_SENSE_I
        |=> POWER_LOW_SEEN_O)
        else $error("power low not latched");

    a_seen_sticky: assert property (
        POWER_LOW_SEEN_O && !clr_q
        |=> POWER_LOW_SEEN_O)
        else $error("power low flag dropped without clear");

    a_halt_one: assert property (
        in_halt
        |-> (!RUN_EN_O && LOW_POWER_O) ##halt_cyc !in_halt)
        else $error("halt cycle ran core or lasted too long");

    c_standby: cover property (in_stby ##1 in_stby);
    c_gate_wake: cover property (gate_wake ##1 in_run);
    c_clear_wake: cover property (in_stby && ext_clear);
    c_gate_refused: cover property (
        in_run && HALT_EXEC_I && !STANDBY_GATE_PIN_I);
    c_run_clear: cover property (in_run && ext_clear && !clr_q);
endmodule

/* File: rtl/shc_consts.svh */
`ifndef SHC_CONSTS_SVH
`define SHC_CONSTS_SVH
`define SHC_PC_W        10
`define SHC_PC_RESET    10'h000
`define SHC_HALT_CYCLES 1
`endif

/* File: rtl/shc_pkg.sv */
package shc_pkg;
    typedef enum logic [1:0] {
        SHC_RUN,
        SHC_HALT_EXEC,
        SHC_STANDBY
    } shc_state_e;
    typedef struct packed {
        logic run_en;
        logic standby;
        logic low_power;
    } shc_status_s;
endpackage

/* File: verif/shc_power_net.sv */
module shc_power_net (
    input  wire logic clk_i,
    input  wire logic halt_i,
    input  wire logic clr_req_i,
    input  wire logic gate_req_i,
    input  wire logic sense_req_i,
    output logic      clear_n_o,
    output logic      gate_o,
    output logic      sense_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic freeze_q = 1'b0;
    initial begin
        clear_n_o = 1'b1;
        gate_o = 1'b1;
        sense_o = 1'b1;
    end
    // lines held still through the halt cycle
    always @(posedge clk_i) begin
        freeze_q <= halt_i;
        if (!halt_i && !freeze_q) begin
            clear_n_o <= clr_req_i;
            gate_o <= gate_req_i;
            sense_o <= sense_req_i;
        end
    end
endmodule

/* File: verif/standby_halt_control_tb.sv */
`include "shc_consts.svh"
module standby_halt_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n, halt, adv, clr_req, gate_req, sense_req;
    logic [`SHC_PC_W-1:0] pc_nx, exp_pc, pc;
    logic clr_n, gate, sense, run, stby, lp, crst, seen;
    int error_cnt = 0, check_count = 0, cyc = 0;
    shc_power_net net_u (.clk_i(clk), .halt_i(halt), .clr_req_i(clr_req),
        .gate_req_i(gate_req), .sense_req_i(sense_req), .clear_n_o(clr_n),
        .gate_o(gate), .sense_o(sense));
    shc_standby_ctrl #(.PC_W(`SHC_PC_W)) dut_u (.REF_CLK_I(clk),
        .RESET_N_I(rst_n), .EXTERNAL_CLEAR_N_I(clr_n),
        .STANDBY_GATE_PIN_I(gate), .HALT_EXEC_I(halt),
        .POWER_SENSE_I(sense), .PC_ADVANCE_I(adv), .PC_NEXT_I(pc_nx),
        .PC_O(pc), .RUN_EN_O(run), .STANDBY_O(stby), .LOW_POWER_O(lp),
        .CORE_RESET_O(crst), .POWER_LOW_SEEN_O(seen));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    function automatic logic [`SHC_PC_W-1:0] pc_expect(input bit cleared,
            input logic [`SHC_PC_W-1:0] held);
        return cleared ? `SHC_PC_RESET : held;
    endfunction
    task automatic check(input string nm, input logic [`SHC_PC_W-1:0] e,
                         input logic [`SHC_PC_W-1:0] g);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic do_clear;
        clr_req = 1'b0;
        tick(2);
        check("core_reset", 1, crst);
        clr_req = 1'b1;
        tick(4);
        check("pc_clear", pc_expect(1'b1, exp_pc), pc);
        check("run_after_clear", 1, run);
    endtask
    task automatic tally_and_finish;
        $display("errors %0d checks %0d", error_cnt, check_count);
        if (error_cnt == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    initial begin
        {rst_n, halt, adv} = 3'h0;
        {clr_req, gate_req, sense_req} = 3'h7;
        pc_nx = 10'h000;
        void'($urandom(98));
        tick(6);
        rst_n = 1'b1;
        tick(4);
        check("pc_after_reset", pc_expect(1'b1, pc_nx), pc);
        repeat (8) begin
            pc_nx = 10'($urandom());
            adv = 1'b1;
            tick(1);
            adv = 1'b0;
            check("pc_run", pc_nx, pc);
        end
        gate_req = 1'b0;
        tick(2);
        halt = 1'b1;
        tick(1);
        halt = 1'b0;
        tick(2);
        check("standby_gate_low", 0, stby);
        gate_req = 1'b1;
        tick(2);
        for (int w = 0; w < 2; w++) begin
            exp_pc = pc;
            halt = 1'b1;
            tick(1);
            halt = 1'b0;
            check("low_power", 1, lp);
            check("run_en_halt", 0, run);
            tick(1);
            check("standby", 1, stby);
            pc_nx = ~exp_pc;
            adv = 1'b1;
            tick(2);
            adv = 1'b0;
            check("pc_hold", pc_expect(1'b0, exp_pc), pc);
            check("low_power_stby", 1, lp);
            if (w == 0) begin
                gate_req = 1'b0;
                tick(2);
                check("wake", 0, stby);
                check("run_wake", 1, run);
                check("pc_resume", pc_expect(1'b0, exp_pc), pc);
                gate_req = 1'b1;
                tick(2);
            end else begin
                do_clear();
                check("standby_clr", 0, stby);
            end
        end
        sense_req = 1'b0;
        tick(3);
        sense_req = 1'b1;
        tick(3);
        check("power_low_seen", 1, seen);
        do_clear();
        check("seen_cleared", 0, seen);
        tally_and_finish();
    end
endmodule
